// ==== shared/wdt_link_if.sv ====
// Carrier between the configuration front end and the countdown timer.
// Both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface wdt_link_if;
  logic       load;      // Pulse: reload count from F6 value
  logic       restart;   // Pulse: activity restart
  logic       run;       // Watchdog enabled
  logic       unit_min;  // Count minutes instead of seconds
  logic [7:0] count;     // Stored timeout value
  logic       expire;    // Pulse: countdown reached zero
  modport ctrl
  (
    output load, restart, run, unit_min, count,
    input  expire
  );
  modport tmr
  (
    input  load, restart, run, unit_min, count,
    output expire
  );
endinterface
`default_nettype wire

// ==== shared/wdt_pkg.sv ====
// Constants shared by the watchdog configuration front end and its timer.
// Assumes a 100 MHz system clock.
package wdt_pkg;
  // I/O ports of the index/data pair
  localparam logic [15:0] IDX_PORT   = 16'h002E;
  localparam logic [15:0] DATA_PORT  = 16'h002F;
  // Keys written to the index port
  localparam logic [7:0]  KEY_UNLOCK = 8'h87;
  localparam logic [7:0]  KEY_LOCK   = 8'hAA;
  // Register indices
  localparam logic [7:0]  REG_LDN    = 8'h07;
  localparam logic [7:0]  REG_ACT    = 8'h30;
  localparam logic [7:0]  REG_UNIT   = 8'hF5;
  localparam logic [7:0]  REG_COUNT  = 8'hF6;
  localparam logic [7:0]  REG_CTRL   = 8'hF7;
  // Logical device number of the watchdog
  localparam logic [7:0]  LDN_WDT    = 8'h08;
  // Read answers and reset values
  localparam logic [7:0]  RD_LOCKED  = 8'hFF;
  localparam logic [7:0]  RD_NONE    = 8'h00;
  localparam logic [7:0]  COUNT_STOP = 8'h00;
  localparam logic [7:0]  LDN_RST    = 8'h00;
  // Bit positions
  localparam int          ACT_BIT    = 0;
  localparam int          UNIT_BIT   = 3;
  localparam int          STAT_BIT   = 4;
  localparam int          FORCE_BIT  = 5;
  localparam int          KBD_BIT    = 6;
  localparam int          MOUSE_BIT  = 7;
  // Timing: clock period and counting units
  localparam int          CLK_PERIOD_NS = 32'h0000000A;
  localparam int          UNIT_SEC_NS   = 32'h3B9ACA00;
  localparam int          SEC_CYCLES    = UNIT_SEC_NS / CLK_PERIOD_NS;
  localparam logic [5:0]  SECS_PER_MIN  = 6'h3C;
  // Configuration lock states
  typedef enum logic [1:0]
  {
    CFG_LOCKED = 2'b00,
    CFG_KEY1   = 2'b01,
    CFG_OPEN   = 2'b10
  } cfg_state_t;
endpackage

// ==== src/superio_wdt.sv ====
// Watchdog logical device reached through an index/data I/O port pair.
// Assumes one-cycle I/O strobes synchronous to clk.
// Function
// - Index port selects, data port moves value
// - Index 07h value 08h selects watchdog
// - 30h bit0 enables; controls need enable
// - F7 bit7 lets mouse restart count
// - F7 bit6 lets keyboard restart count
// - F7 bit5 write forces timeout at once
// - Forced timeout needs no running count
// - AAh on index locks, writes ignored
// - F5 bit3 selects seconds or minutes
// - F6 zero stops, nonzero reloads countdown
// - Force bit clears itself
// - F7 bit4 reads timeout status
`timescale 1ns/1ps
`default_nettype none
module superio_wdt
#(
  parameter int SEC_CYCLES = wdt_pkg::SEC_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic        mouse_act,
  input  wire logic        kbd_act,
  output logic             wdt_timeout
);
  import wdt_pkg::*;

  // ==========================================================
  // State
  typedef struct packed
  {
    cfg_state_t lock;      // Configuration lock state
    logic [7:0] index;     // Selected register index
    logic [7:0] ldn;       // Selected logical device
    logic       act;       // Watchdog enabled
    logic       unit_min;  // Minute unit
    logic [7:0] count;     // Timeout value
    logic       mouse_en;  // Mouse restarts count
    logic       kbd_en;    // Keyboard restarts count
    logic       status;    // Timeout reached
    logic       load;      // Count reload pulse
    logic [7:0] rdata;     // Read answer
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;

  wdt_link_if link ();

  // Decoded strobes
  logic       wr_idx;      // Index port write
  logic       wr_dat;      // Data port write
  logic       rd_idx;      // Index port read
  logic       rd_dat;      // Data port read
  logic       is_open;     // Configuration unlocked
  logic       wdt_sel;     // Watchdog device selected
  logic       ctl_wr;      // Enabled watchdog control write
  logic       force_hit;   // Force timeout write
  logic       activity;    // Enabled activity restart
  logic [7:0] rd_val;      // Data port read value

  assign wr_idx  = io_wr && io_addr == IDX_PORT;
  assign wr_dat  = io_wr && io_addr == DATA_PORT;
  assign rd_idx  = io_rd && io_addr == IDX_PORT;
  assign rd_dat  = io_rd && io_addr == DATA_PORT;
  assign is_open = st_ff.lock == CFG_OPEN;
  assign wdt_sel = st_ff.ldn == LDN_WDT;
  assign ctl_wr  = wr_dat && is_open && wdt_sel && st_ff.act;
  assign force_hit = ctl_wr && st_ff.index == REG_CTRL && io_wdata[FORCE_BIT];
  assign activity = st_ff.act
                    && ((mouse_act && st_ff.mouse_en) || (kbd_act && st_ff.kbd_en));

  // ==========================================================
  // Read multiplexer
  always_comb
  begin
    rd_val = RD_NONE;
    if (st_ff.index == REG_LDN)
      rd_val = st_ff.ldn;
    else if (wdt_sel)
    begin
      unique case (st_ff.index)
        REG_ACT:   rd_val[ACT_BIT] = st_ff.act;
        REG_UNIT:  rd_val[UNIT_BIT] = st_ff.unit_min;
        REG_COUNT: rd_val = st_ff.count;
        REG_CTRL:
        begin
          rd_val[MOUSE_BIT] = st_ff.mouse_en;
          rd_val[KBD_BIT]   = st_ff.kbd_en;
          rd_val[STAT_BIT]  = st_ff.status;
        end
        default:   rd_val = RD_NONE;
      endcase
    end
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.load = 1'b0;
    // Lock sequencer
    unique case (st_ff.lock)
      CFG_LOCKED:
      begin
        if (wr_idx && io_wdata == KEY_UNLOCK)
          nxt_st.lock = CFG_KEY1;
      end
      CFG_KEY1:
      begin
        if (wr_idx && io_wdata == KEY_UNLOCK)
          nxt_st.lock = CFG_OPEN;
        else if (io_wr)
          nxt_st.lock = CFG_LOCKED;
      end
      CFG_OPEN:
      begin
        if (wr_idx && io_wdata == KEY_LOCK)
          nxt_st.lock = CFG_LOCKED;
        else if (wr_idx)
          nxt_st.index = io_wdata;
      end
      default: nxt_st.lock = CFG_LOCKED;
    endcase
    if (wr_dat && is_open && st_ff.index == REG_LDN)
      nxt_st.ldn = io_wdata;
    if (wr_dat && is_open && wdt_sel && st_ff.index == REG_ACT)
      nxt_st.act = io_wdata[ACT_BIT];
    if (ctl_wr && st_ff.index == REG_UNIT)
      nxt_st.unit_min = io_wdata[UNIT_BIT];
    if (ctl_wr && st_ff.index == REG_COUNT)
    begin
      nxt_st.count = io_wdata;
      nxt_st.load  = 1'b1;
    end
    if (ctl_wr && st_ff.index == REG_CTRL)
    begin
      nxt_st.mouse_en = io_wdata[MOUSE_BIT];
      nxt_st.kbd_en   = io_wdata[KBD_BIT];
      // Writing 0 to status clears it
      if (!io_wdata[STAT_BIT])
        nxt_st.status = 1'b0;
    end
    if (force_hit || link.expire)
      nxt_st.status = 1'b1;
    // Read answer
    if (rd_idx)
      nxt_st.rdata = is_open ? st_ff.index : RD_LOCKED;
    else if (rd_dat)
      nxt_st.rdata = is_open ? rd_val : RD_LOCKED;
  end

  // Register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_ff       <= '0;
      st_ff.lock  <= CFG_LOCKED;
      st_ff.ldn   <= LDN_RST;
      st_ff.count <= COUNT_STOP;
    end
    else
      st_ff <= nxt_st;
  end

  // ==========================================================
  // Timer and outputs
  assign link.load     = st_ff.load;
  assign link.restart  = activity;
  assign link.run      = st_ff.act;
  assign link.unit_min = st_ff.unit_min;
  assign link.count    = st_ff.count;

  wdt_timer #(.SEC_CYCLES(SEC_CYCLES)) u_timer
  (
    .clk  (clk),
    .srst (srst),
    .lnk  (link.tmr)
  );

  assign io_rdata    = st_ff.rdata;
  assign wdt_timeout = st_ff.status;

  // ==========================================================
  // Checks
  // Two keys one idle cycle apart, the host's usual strobe spacing
  sequence s_key_key;
    wr_idx && io_wdata == KEY_UNLOCK && st_ff.lock == CFG_LOCKED
    ##1 !io_wr
    ##1 wr_idx && io_wdata == KEY_UNLOCK;
  endsequence
  property p_unlock;
    @(posedge clk) disable iff (srst) s_key_key |=> is_open;
  endproperty
  a_unlock: assert property (p_unlock) else $error("two keys did not unlock");

  property p_lock;
    @(posedge clk) disable iff (srst)
      is_open && wr_idx && io_wdata == KEY_LOCK |=> st_ff.lock == CFG_LOCKED;
  endproperty
  a_lock: assert property (p_lock) else $error("lock key ignored");

  property p_locked_ignore;
    @(posedge clk) disable iff (srst)
      !is_open && wr_dat |=> $stable(st_ff.ldn) && $stable(st_ff.count) && $stable(st_ff.act);
  endproperty
  a_locked_ignore: assert property (p_locked_ignore) else $error("locked write");

  property p_select;
    @(posedge clk) disable iff (srst)
      wr_dat && is_open && st_ff.index == REG_LDN |=> st_ff.ldn == $past(io_wdata);
  endproperty
  a_select: assert property (p_select) else $error("device select lost");

  property p_force;
    @(posedge clk) disable iff (srst)
      force_hit |=> wdt_timeout ##1 (wdt_timeout || $past(ctl_wr));
  endproperty
  a_force: assert property (p_force) else $error("forced timeout missing");

  property p_disabled;
    @(posedge clk) disable iff (srst)
      !st_ff.act && wr_dat |=> $stable(st_ff.mouse_en) && $stable(st_ff.count);
  endproperty
  a_disabled: assert property (p_disabled) else $error("write while disabled");

  property p_restart;
    @(posedge clk) disable iff (srst)
      st_ff.act && mouse_act && st_ff.mouse_en
      |=> u_timer.st_ff.cnt == $past(st_ff.count);
  endproperty
  a_restart: assert property (p_restart) else $error("mouse restart missing");

  property p_kbd_restart;
    @(posedge clk) disable iff (srst)
      st_ff.act && kbd_act && st_ff.kbd_en
      |=> u_timer.st_ff.cnt == $past(st_ff.count);
  endproperty
  a_kbd_restart: assert property (p_kbd_restart) else $error("no key restart");

  property p_status_rd;
    @(posedge clk) disable iff (srst)
      rd_dat && is_open && wdt_sel && st_ff.index == REG_CTRL
      |=> io_rdata[STAT_BIT] == $past(st_ff.status) && !io_rdata[FORCE_BIT];
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status readback wrong");

  property p_expire_flag;
    @(posedge clk) disable iff (srst) link.expire |=> wdt_timeout;
  endproperty
  a_expire_flag: assert property (p_expire_flag) else $error("expiry not flagged");
endmodule
`default_nettype wire

// ==== src/wdt_timer.sv ====
// Countdown timer of the watchdog, in seconds or minutes.
// Expects load/restart pulses and settings from the front end.
`timescale 1ns/1ps
`default_nettype none
module wdt_timer
#(
  parameter int SEC_CYCLES = wdt_pkg::SEC_CYCLES
)
(
  input  wire logic clk,
  input  wire logic srst,
  wdt_link_if.tmr   lnk
);
  import wdt_pkg::*;

  // ==========================================================
  // State
  typedef struct packed
  {
    logic [31:0] pre;     // Cycles within one second
    logic [5:0]  secs;    // Seconds within one minute
    logic [7:0]  cnt;     // Remaining units
    logic        expire;  // Expiry pulse
  } tmr_state_t;

  tmr_state_t st_ff;
  tmr_state_t nxt_st;

  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.expire = 1'b0;
    if (lnk.load || lnk.restart)
    begin
      nxt_st.cnt  = lnk.count;
      nxt_st.pre  = '0;
      nxt_st.secs = '0;
    end
    else if (lnk.run && st_ff.cnt != COUNT_STOP)
    begin
      if (st_ff.pre == 32'(SEC_CYCLES - 1))
      begin
        nxt_st.pre = '0;
        if (!lnk.unit_min || st_ff.secs == SECS_PER_MIN - 6'h01)
        begin
          nxt_st.secs = '0;
          nxt_st.cnt  = st_ff.cnt - 8'h01;
          nxt_st.expire = (st_ff.cnt == 8'h01);
        end
        else
        begin
          nxt_st.secs = st_ff.secs + 6'h01;
        end
      end
      else
      begin
        nxt_st.pre = st_ff.pre + 32'h00000001;
      end
    end
  end

  // Register
  always_ff @(posedge clk)
  begin
    if (srst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign lnk.expire = st_ff.expire;

  // ==========================================================
  // Checks
  // load takes value
  property p_load;
    @(posedge clk) disable iff (srst)
      lnk.load |=> st_ff.cnt == $past(lnk.count);
  endproperty
  a_load: assert property (p_load) else $error("load did not take count");

  property p_expire;
    @(posedge clk) disable iff (srst)
      lnk.expire |-> st_ff.cnt == COUNT_STOP && $past(st_ff.cnt) == 8'h01;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry without countdown end");

  property p_stop;
    @(posedge clk) disable iff (srst)
      st_ff.cnt == COUNT_STOP && !lnk.load && !lnk.restart |=> st_ff.cnt == COUNT_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped timer moved");
endmodule
`default_nettype wire

// ==== testbench/superio_wdt_tb.sv ====
// Self-checking bench for the watchdog reached through the index/data port pair.
// Assumes the package and the design files are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module superio_wdt_tb;
  import wdt_pkg::*;
  // ==========================================================
  // Signals and counters
  localparam int SEC = 4;        // Short second unit for simulation
  logic        clk;              // System clock
  logic        srst;             // Synchronous reset
  logic [15:0] io_addr;          // I/O address
  logic        io_wr;            // Write strobe
  logic        io_rd;            // Read strobe
  logic [7:0]  io_wdata;         // Write data
  logic [7:0]  io_rdata;         // Read data
  logic        mouse_act;        // Mouse activity
  logic        kbd_act;          // Keyboard activity
  logic        wdt_timeout;      // Timeout output
  int          mismatches;       // Mismatch count
  int          checked;          // Comparison count
  logic [7:0]  rd;               // Last value read

  // ==========================================================
  // Device under test
  superio_wdt #(.SEC_CYCLES(SEC)) i_superio_wdt
  (
    .clk         (clk),
    .srst        (srst),
    .io_addr     (io_addr),
    .io_wr       (io_wr),
    .io_rd       (io_rd),
    .io_wdata    (io_wdata),
    .io_rdata    (io_rdata),
    .mouse_act   (mouse_act),
    .kbd_act     (kbd_act),
    .wdt_timeout (wdt_timeout)
  );

  // ==========================================================
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Tasks
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe, driven on the falling edge
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(negedge clk);
    io_wr    = 1'b0;
  endtask

  // One-cycle read strobe; data is taken once it has settled
  task automatic io_read(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_rd   = 1'b1;
    @(negedge clk);
    io_rd   = 1'b0;
    @(negedge clk);
    d = io_rdata;
  endtask

  // Indexed register write and read
  task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
    io_write(IDX_PORT, idx);
    io_write(DATA_PORT, d);
  endtask

  task automatic reg_read(input logic [7:0] idx, output logic [7:0] d);
    io_write(IDX_PORT, idx);
    io_read(DATA_PORT, d);
  endtask

  // Read-modify-write that sets the given bits
  task automatic reg_set(input logic [7:0] idx, input logic [7:0] mask);
    logic [7:0] v;
    reg_read(idx, v);
    io_write(DATA_PORT, v | mask);
  endtask

  // Stop the timer and clear status and activity enables
  task automatic stop_clear();
    reg_write(REG_COUNT, 8'h00);
    reg_write(REG_CTRL, 8'h00);
    check({15'h0000, wdt_timeout}, 16'h0000);
  endtask

  // Five activity pulses, spaced closer than a three-unit count
  task automatic pulse_act(input logic is_mouse);
    repeat (5)
    begin
      @(negedge clk);
      mouse_act = is_mouse;
      kbd_act   = !is_mouse;
      @(negedge clk);
      mouse_act = 1'b0;
      kbd_act   = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask

  // Wait for timeout; the cycle count must fall in the window
  task automatic wait_to(input int lo, input int hi);
    int   n;
    logic ok;
    n = 0;
    while (wdt_timeout !== 1'b1 && n < hi + 8)
    begin
      @(negedge clk);
      n++;
    end
    ok = (n >= lo) && (n <= hi);
    check({15'h0000, ok}, 16'h0001);
  endtask

  // Print counts and verdict, then stop
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Watchdog against a hang
  initial
  begin
    #60000;
    mismatches++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    srst       = 1'b1;
    io_addr    = 16'h0000;
    io_wr      = 1'b0;
    io_rd      = 1'b0;
    io_wdata   = 8'h00;
    mouse_act  = 1'b0;
    kbd_act    = 1'b0;
    mismatches = 0;
    checked    = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    check({15'h0000, wdt_timeout}, 16'h0000);
    // Locked device answers reads with all ones
    io_read(DATA_PORT, rd);
    check({8'h00, rd}, {8'h00, RD_LOCKED});
    // Broken key sequence leaves it locked
    io_write(IDX_PORT, KEY_UNLOCK);
    io_write(DATA_PORT, 8'h55);
    io_write(IDX_PORT, KEY_UNLOCK);
    io_read(DATA_PORT, rd);
    check({8'h00, rd}, 16'h00FF);
    // Second key completes the unlock
    io_write(IDX_PORT, KEY_UNLOCK);
    reg_write(REG_LDN, LDN_WDT);
    reg_read(REG_LDN, rd);
    check({8'h00, rd}, 16'h0008);
    io_read(IDX_PORT, rd);
    check({8'h00, rd}, {8'h00, REG_LDN});
    // Force is ignored while the function is disabled
    reg_write(REG_CTRL, 8'h20);
    @(negedge clk);
    check({15'h0000, wdt_timeout}, 16'h0000);
    reg_write(REG_ACT, 8'h01);
    reg_read(REG_ACT, rd);
    check({8'h00, rd}, 16'h0001);
    // Forced timeout with no count loaded
    reg_set(REG_CTRL, 8'h20);
    check({15'h0000, wdt_timeout}, 16'h0001);
    io_read(DATA_PORT, rd);
    check({8'h00, rd & 8'h30}, 16'h0010);
    stop_clear();
    // Three-second countdown expires
    reg_write(REG_COUNT, 8'h03);
    wait_to(3 * SEC - 2, 3 * SEC + 4);
    reg_read(REG_CTRL, rd);
    check({8'h00, rd & 8'h10}, 16'h0010);
    stop_clear();
    // Keyboard pulses ignored while its enable is clear
    reg_write(REG_COUNT, 8'h03);
    pulse_act(1'b0);
    check({15'h0000, wdt_timeout}, 16'h0001);
    stop_clear();
    // Keyboard enabled by read-modify-write keeps the timer alive
    reg_set(REG_CTRL, 8'h40);
    reg_read(REG_CTRL, rd);
    check({8'h00, rd}, 16'h0040);
    reg_write(REG_COUNT, 8'h03);
    pulse_act(1'b0);
    check({15'h0000, wdt_timeout}, 16'h0000);
    // Last restart lies four cycles before the pulse task returns
    wait_to(3 * SEC - 4, 3 * SEC);
    stop_clear();
    // Mouse enabled keeps the timer alive
    reg_set(REG_CTRL, 8'h80);
    reg_write(REG_COUNT, 8'h03);
    pulse_act(1'b1);
    check({15'h0000, wdt_timeout}, 16'h0000);
    wait_to(3 * SEC - 4, 3 * SEC);
    stop_clear();
    // Zero count stops a running countdown
    reg_write(REG_COUNT, 8'h03);
    reg_write(REG_COUNT, 8'h00);
    repeat (40) @(negedge clk);
    check({15'h0000, wdt_timeout}, 16'h0000);
    // Minute unit: sixty seconds per count
    reg_set(REG_UNIT, 8'h08);
    reg_read(REG_UNIT, rd);
    check({8'h00, rd & 8'h08}, 16'h0008);
    reg_write(REG_COUNT, 8'h01);
    wait_to(60 * SEC - 10, 60 * SEC + 10);
    stop_clear();
    reg_write(REG_COUNT, 8'h05);
    // Lock, then a data write must not land
    io_write(IDX_PORT, KEY_LOCK);
    io_write(DATA_PORT, 8'h77);
    io_read(IDX_PORT, rd);
    check({8'h00, rd}, 16'h00FF);
    io_write(IDX_PORT, KEY_UNLOCK);
    io_write(IDX_PORT, KEY_UNLOCK);
    reg_read(REG_COUNT, rd);
    check({8'h00, rd}, 16'h0005);
    finish_test();
  end
endmodule
`default_nettype wire
